// ==== core/eepc_defines.vh ====
`ifndef EEPC_DEFINES_VH
`define EEPC_DEFINES_VH
`define EEPC_OP_SET_LATCH 7'h06
`define EEPC_OP_CLR_LATCH 7'h04
`define EEPC_OP_STAT_RD 7'h05
`define EEPC_OP_STAT_WR 7'h01
`define EEPC_OP_ARR_RD 7'h03
`define EEPC_OP_ARR_WR 7'h02
`define EEPC_SR_BUSY 0
`define EEPC_SR_LATCH 1
`define EEPC_SR_LVL0 2
`define EEPC_SR_LVL1 3
`define EEPC_SR_LVL2 4
`define EEPC_SR_LOCK 7
`define EEPC_SR_BUSY_VAL 8'hFF
`define EEPC_WRITE_TIME_US 5000
`define EEPC_CLK_MHZ 10
`define EEPC_WRITE_CYCLES (`EEPC_WRITE_TIME_US * `EEPC_CLK_MHZ)
`define EEPC_PROT_QTR 16'hC000
`define EEPC_PROT_HALF 16'h8000
`endif

// ==== core/eepc_skid.v ====
`include "eepc_defines.vh"
`default_nettype none
// Two-entry buffer: ready depends only on occupancy, so no combinational path through it
module eepc_skid #(
    parameter WIDTH = 24
) (
    input wire clk_sys,
    input wire reset,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] slot0;
    reg [WIDTH-1:0] slot1;
    reg [1:0] count;
    wire push;
    wire pop;
    assign in_ready = (count != 2'd2);
    assign out_valid = (count != 2'd0);
    assign out_data = slot0;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    always @(posedge clk_sys) begin
        if (reset) begin
            count <= 2'd0;
            slot0 <= {WIDTH{1'b0}};
            slot1 <= {WIDTH{1'b0}};
        end else begin
            case ({push, pop})
                2'b10: begin
                    if (count == 2'd0)
                        slot0 <= in_data;
                    else
                        slot1 <= in_data;
                    count <= count + 2'd1;
                end
                2'b01: begin
                    slot0 <= slot1;
                    count <= count - 2'd1;
                end
                2'b11: begin
                    if (count == 2'd1)
                        slot0 <= in_data;
                    else begin
                        slot0 <= slot1;
                        slot1 <= in_data;
                    end
                end
                default: begin
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// ==== core/eepc_core.v ====
// Function
// - Status bit 0 reads 1 while busy writing, 0 when ready.
// - While busy only status read is honoured; status reads all ones.
// - With write latch clear nothing, status or array, can change.
// - Reset clears the write latch.
// - Set-latch instruction sets the write latch.
// - Clear-latch, status write and array write completion clear the latch.
// - Block-protect bits 2..4 are kept, reset to zero; bits 2 and 3 always apply, bit 4 has no effect.
// - Status bits 5 and 6 are not stored and read zero when idle.
// - Bit 7 with protect pin low makes status read-only.
// - Level bits 01 protect C000-FFFF, 10 8000-FFFF, 11 everything.
// - Protected bytes never change; others only with latch set.
// - Status write needs latch and no lock; stores lock and level bits.
// - Status write takes effect when the internal cycle ends.
// - Opcode bit 3 ignored: x6 set latch, x4 clear, x1 status write.
// - Opcode x5 status read, x3 array read, x2 array write.
// - Input sampled on rising serial clock, MSB first; output on falling.
// - Chip select rising ends the command and launches the operation.
// - Array read takes 16-bit address, ascends, wraps to zero.
// - Array write stays in a 128-byte page, low 7 bits wrap.
// - Over a page of data keeps only the final 128 bytes.
// - Status read repeats the status byte while clocking continues.
// - Only mode 0, clock idling low.
`include "eepc_defines.vh"
`default_nettype none
module eepc_core #(
    parameter ADDR_W = 16,
    parameter PAGE_W = 7,
    parameter WRITE_CYCLES = `EEPC_WRITE_CYCLES
) (
    input wire clk_sys,
    input wire reset,
    input wire chip_sel_n,
    input wire ser_clk,
    input wire ser_in,
    input wire protect_n,
    output reg ser_out,
    output reg ser_out_en,
    output reg busy
);
    localparam ST_OP = 3'd0;
    localparam ST_ADDR = 3'd1;
    localparam ST_RDATA = 3'd2;
    localparam ST_WDATA = 3'd3;
    localparam ST_SDATA = 3'd4;
    localparam ST_SREAD = 3'd5;
    localparam ST_IGNORE = 3'd6;
    localparam PAGE_N = 1 << PAGE_W;

    reg [7:0] mem [0:(1 << ADDR_W)-1];
    reg [7:0] page_buf [0:PAGE_N-1];
    reg [PAGE_N-1:0] page_dirty;
    reg [2:0] cs_sync;
    reg [2:0] sck_sync;
    reg [1:0] si_sync;
    reg [1:0] wp_sync;
    reg [2:0] state;
    reg [6:0] opcode;
    reg [15:0] shift;
    reg [4:0] bit_cnt;
    reg [ADDR_W-1:0] addr;
    reg [7:0] out_byte;
    reg [2:0] out_bit;
    reg write_latch;
    reg [2:0] level;
    reg lock_en;
    reg [7:0] pend_status;
    reg arm_arr;
    reg arm_stat;
    reg do_arr;
    reg do_stat;
    reg [31:0] wcount;
    reg [PAGE_W:0] commit_idx;
    reg [ADDR_W-PAGE_W-1:0] page_hi;

    wire cs_act;
    wire sck_rise;
    wire sck_fall;
    wire cs_rise;
    wire cs_fall;
    wire [7:0] status_word;
    wire [7:0] in_byte;
    wire hw_lock;
    wire q_in_ready;
    wire q_out_valid;
    wire [ADDR_W+7:0] q_out_data;
    wire q_push;

    function prot_hit;
        input [1:0] lvl;
        input [15:0] a;
        begin
            case (lvl)
                2'b01: prot_hit = (a >= `EEPC_PROT_QTR);
                2'b10: prot_hit = (a >= `EEPC_PROT_HALF);
                2'b11: prot_hit = 1'b1;
                default: prot_hit = 1'b0;
            endcase
        end
    endfunction

    assign cs_act = ~cs_sync[1];
    assign sck_rise = sck_sync[1] & ~sck_sync[2];
    assign sck_fall = ~sck_sync[1] & sck_sync[2];
    assign cs_rise = cs_sync[1] & ~cs_sync[2];
    assign cs_fall = ~cs_sync[1] & cs_sync[2];
    assign hw_lock = lock_en & ~wp_sync[1];
    assign status_word = busy ? `EEPC_SR_BUSY_VAL :
        {lock_en, 2'b00, level, write_latch, 1'b0};
    assign in_byte = {shift[6:0], si_sync[1]};

    // Received bytes are parked here for a cycle before the page buffer takes them
    eepc_skid #(.WIDTH(ADDR_W + 8)) u_skid (
        .clk_sys(clk_sys),
        .reset(reset),
        .in_valid(q_push),
        .in_ready(q_in_ready),
        .in_data({addr, in_byte}),
        .out_valid(q_out_valid),
        .out_ready(1'b1),
        .out_data(q_out_data)
    );
    assign q_push = cs_act && sck_rise && state == ST_WDATA && bit_cnt == 5'd7 && q_in_ready;

    always @(posedge clk_sys) begin
        if (reset) begin
            cs_sync <= 3'b111;
            sck_sync <= 3'b000;
            si_sync <= 2'b00;
            wp_sync <= 2'b11;
        end else begin
            cs_sync <= {cs_sync[1:0], chip_sel_n};
            sck_sync <= {sck_sync[1:0], ser_clk};
            si_sync <= {si_sync[0], ser_in};
            wp_sync <= {wp_sync[0], protect_n};
        end
    end

    // Page buffer collects data; later bytes overwrite earlier ones in the same slot
    always @(posedge clk_sys) begin
        if (q_out_valid)
            page_buf[q_out_data[PAGE_W+7:8]] <= q_out_data[7:0];
    end

    always @(posedge clk_sys) begin
        // Protection is judged at the write itself; the dirty clear lands a cycle too late
        if (do_arr && commit_idx < PAGE_N && page_dirty[commit_idx[PAGE_W-1:0]] &&
            !prot_hit(level[1:0], {page_hi, commit_idx[PAGE_W-1:0]}))
            mem[{page_hi, commit_idx[PAGE_W-1:0]}] <= page_buf[commit_idx[PAGE_W-1:0]];
    end

    always @(posedge clk_sys) begin
        if (reset) begin
            state <= ST_OP;
            opcode <= 7'h00;
            shift <= 16'h0000;
            bit_cnt <= 5'd0;
            addr <= {ADDR_W{1'b0}};
            out_byte <= 8'h00;
            out_bit <= 3'd0;
            ser_out <= 1'b0;
            ser_out_en <= 1'b0;
            write_latch <= 1'b0;
            level <= 3'b000;
            lock_en <= 1'b0;
            pend_status <= 8'h00;
            arm_arr <= 1'b0;
            arm_stat <= 1'b0;
            do_arr <= 1'b0;
            do_stat <= 1'b0;
            busy <= 1'b0;
            wcount <= 32'd0;
            commit_idx <= {(PAGE_W+1){1'b0}};
            page_hi <= {(ADDR_W-PAGE_W){1'b0}};
            page_dirty <= {PAGE_N{1'b0}};
        end else begin
            if (cs_fall) begin
                state <= ST_OP;
                bit_cnt <= 5'd0;
                arm_arr <= 1'b0;
                arm_stat <= 1'b0;
            end
            if (!cs_act) begin
                ser_out_en <= 1'b0;
                ser_out <= 1'b0;
            end
            if (cs_act && sck_rise) begin
                shift <= {shift[14:0], si_sync[1]};
                bit_cnt <= bit_cnt + 5'd1;
                case (state)
                    ST_OP: begin
                        if (bit_cnt == 5'd7) begin
                            bit_cnt <= 5'd0;
                            opcode <= {in_byte[7:4], in_byte[2:0]};
                            if (busy && in_byte[2:0] != 3'b101)
                                state <= ST_IGNORE;
                            else
                                case (in_byte[2:0])
                                    3'b110: begin
                                        write_latch <= 1'b1;
                                        state <= ST_IGNORE;
                                    end
                                    3'b100: begin
                                        write_latch <= 1'b0;
                                        state <= ST_IGNORE;
                                    end
                                    3'b101: begin
                                        state <= ST_SREAD;
                                        out_byte <= status_word;
                                        out_bit <= 3'd0;
                                    end
                                    3'b001: state <= ST_SDATA;
                                    3'b011: state <= ST_ADDR;
                                    3'b010: state <= ST_ADDR;
                                    default: state <= ST_IGNORE;
                                endcase
                        end
                    end
                    ST_ADDR: begin
                        if (bit_cnt == 5'd15) begin
                            bit_cnt <= 5'd0;
                            addr <= {shift[14:0], si_sync[1]};
                            page_hi <= shift[14:PAGE_W-1];
                            page_dirty <= {PAGE_N{1'b0}};
                            if (opcode[2:0] == 3'b011) begin
                                state <= ST_RDATA;
                                out_byte <= mem[{shift[14:0], si_sync[1]}];
                                out_bit <= 3'd0;
                            end else
                                state <= ST_WDATA;
                        end
                    end
                    ST_WDATA: begin
                        if (bit_cnt == 5'd7) begin
                            bit_cnt <= 5'd0;
                            page_dirty[addr[PAGE_W-1:0]] <= 1'b1;
                            addr[PAGE_W-1:0] <= addr[PAGE_W-1:0] + 1'b1;
                            arm_arr <= 1'b1;
                        end else
                            arm_arr <= 1'b0;
                    end
                    ST_SDATA: begin
                        if (bit_cnt == 5'd7) begin
                            bit_cnt <= 5'd0;
                            pend_status <= in_byte;
                            arm_stat <= 1'b1;
                        end else
                            arm_stat <= 1'b0;
                    end
                    default: begin
                        if (state == ST_RDATA && out_bit == 3'd7) begin
                            addr <= addr + 1'b1;
                            out_byte <= mem[addr + 1'b1];
                        end
                        if (state == ST_SREAD && out_bit == 3'd7)
                            out_byte <= status_word;
                        if (state == ST_RDATA || state == ST_SREAD)
                            out_bit <= out_bit + 3'd1;
                    end
                endcase
            end
            if (cs_act && sck_fall && (state == ST_RDATA || state == ST_SREAD)) begin
                ser_out_en <= 1'b1;
                ser_out <= out_byte[3'd7 - out_bit];
            end
            if (cs_rise) begin
                if (arm_arr && write_latch) begin
                    do_arr <= 1'b1;
                    busy <= 1'b1;
                    wcount <= 32'd0;
                    commit_idx <= {(PAGE_W+1){1'b0}};
                end else if (arm_stat && write_latch && !hw_lock) begin
                    do_stat <= 1'b1;
                    busy <= 1'b1;
                    wcount <= 32'd0;
                end
            end
            if (do_arr) begin
                if (commit_idx < PAGE_N) begin
                    if (prot_hit(level[1:0], {page_hi, commit_idx[PAGE_W-1:0]}))
                        page_dirty[commit_idx[PAGE_W-1:0]] <= 1'b0;
                    commit_idx <= commit_idx + 1'b1;
                end
            end
            if (busy) begin
                wcount <= wcount + 32'd1;
                if (wcount == WRITE_CYCLES - 1) begin
                    busy <= 1'b0;
                    do_arr <= 1'b0;
                    do_stat <= 1'b0;
                    write_latch <= 1'b0;
                    if (do_stat) begin
                        lock_en <= pend_status[`EEPC_SR_LOCK];
                        level <= pend_status[`EEPC_SR_LVL2:`EEPC_SR_LVL0];
                    end
                end
            end
        end
    end
endmodule
`default_nettype wire

// ==== verification/eepc_assertions.sv ====
`default_nettype none
module eepc_assertions #(parameter int WRITE_CYCLES = 400) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic chip_sel_n,
    input wire logic ser_clk,
    input wire logic ser_out,
    input wire logic ser_out_en,
    input wire logic busy
);
    timeunit 1ns;
    timeprecision 1ns;
    // Length of the running write cycle, judged on the cycle busy drops
    int cnt;
    always @(posedge clk_sys) cnt <= (reset || !busy) ? 0 : cnt + 1;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    reset_quiet_a: assert property (disable iff (1'b0)
        $fell(reset) |-> !busy && !ser_out_en) else $error("active after reset");
    idle_low_a: assert property (!ser_out_en |-> !ser_out)
        else $error("output high while released");
    out_edge_a: assert property ($changed(ser_out) && $past(ser_out_en) |-> !ser_clk)
        else $error("output moved while serial clock high");
    cs_quiet_a: assert property (chip_sel_n [*8] |-> !ser_out_en)
        else $error("driving while deselected");
    busy_ones_a: assert property (busy && ser_out_en |-> ser_out)
        else $error("status bit low while busy");
    busy_start_a: assert property ($rose(busy) |-> chip_sel_n && $past(chip_sel_n))
        else $error("write cycle began inside a frame");
    busy_len_a: assert property ($fell(busy) |-> cnt == WRITE_CYCLES)
        else $error("write cycle length wrong");
    busy_max_a: assert property (busy |-> cnt < WRITE_CYCLES)
        else $error("write cycle overran");
    cover property ($fell(busy));
    cover property ($rose(ser_out_en));
    cover property (busy && ser_out_en);
endmodule
`default_nettype wire

// ==== verification/eepc_master_model.sv ====
`default_nettype none
module eepc_master_model (
    input wire logic clk_sys,
    input wire logic ser_out,
    output var logic chip_sel_n = 1'b1,
    output var logic ser_clk = 1'b0,
    output var logic ser_in = 1'b0
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [63:0] rx;
    task start();
        @(posedge clk_sys);
        chip_sel_n <= 1'b0;
    endtask
    // Four system clocks per half period give the 800 ns serial clock
    task shift(input int n, input logic [63:0] d);
        for (int i = n - 1; i >= 0; i--) begin
            ser_in <= d[i];
            repeat (4) @(posedge clk_sys);
            ser_clk <= 1'b1;
            rx = {rx[62:0], ser_out};
            repeat (4) @(posedge clk_sys);
            ser_clk <= 1'b0;
        end
    endtask
    task stop();
        repeat (4) @(posedge clk_sys);
        chip_sel_n <= 1'b1;
        // Released data line flips so a stale bit never looks valid
        ser_in <= ~ser_in;
        repeat (8) @(posedge clk_sys);
    endtask
endmodule
`default_nettype wire

// ==== verification/tb.sv ====
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int WCYC = 400;
    logic clk_sys = 1'b0, reset = 1'b1, protect_n = 1'b1;
    wire logic chip_sel_n, ser_clk, ser_in, ser_out, ser_out_en, busy;
    // Released output reads as a pulled-up line, so an undriven bit never looks like data
    wire logic out_line;
    assign out_line = ser_out_en ? ser_out : 1'b1;
    int n_mismatch = 0, total_checks = 0;
    always #50 clk_sys = ~clk_sys;
    eepc_core #(.WRITE_CYCLES(WCYC)) dut (.clk_sys(clk_sys), .reset(reset),
        .chip_sel_n(chip_sel_n), .ser_clk(ser_clk), .ser_in(ser_in), .protect_n(protect_n),
        .ser_out(ser_out), .ser_out_en(ser_out_en), .busy(busy));
    eepc_master_model m (.clk_sys(clk_sys), .ser_out(out_line), .chip_sel_n(chip_sel_n),
        .ser_clk(ser_clk), .ser_in(ser_in));
    task chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task frame(input int n, input logic [63:0] d);
        m.start();
        m.shift(n, d);
        m.stop();
    endtask
    task expect_frame(input int n, input logic [63:0] d, input logic [15:0] e);
        frame(n, d);
        chk(m.rx[15:0], e);
    endtask
    task wait_idle();
        for (int k = 0; k < 2000 && busy !== 1'b0; k++)
            @(posedge clk_sys);
        chk({15'h0, busy}, 16'h0);
        frame(16, 64'h0500); // First ready byte is not trusted
    endtask
    task write_op(input int n, input logic [63:0] d);
        frame(8, 64'h06);
        frame(n, d);
        wait_idle();
    endtask
    task conclude();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task t_latch();
        expect_frame(16, 64'h0500, 16'hFF00);
        frame(16, 64'h0184);
        expect_frame(16, 64'h0500, 16'hFF00);
        frame(8, 64'h0E);
        expect_frame(24, 64'h050000, 16'h0202);
        frame(8, 64'h0C);
        expect_frame(16, 64'h0500, 16'hFF00);
    endtask
    task t_swr();
        frame(8, 64'h06);
        frame(16, 64'h01FC);
        frame(8, 64'h06);
        expect_frame(16, 64'h0500, 16'hFFFF);
        wait_idle();
        expect_frame(16, 64'h0500, 16'hFF9C);
        @(posedge clk_sys) protect_n <= 1'b0;
        write_op(16, 64'h0100);
        frame(16, 64'h0500);
        chk(m.rx[15:0] & 16'hFFFD, 16'hFF9C);
        @(posedge clk_sys) protect_n <= 1'b1;
        frame(8, 64'h06);
        frame(16, 64'h0100);
        repeat (WCYC) @(posedge clk_sys); // Fixed wait instead of polling
        expect_frame(16, 64'h0500, 16'hFF00);
    endtask
    task t_arr();
        write_op(32, 64'h02C000A5);
        write_op(32, 64'h02FFFF3C);
        write_op(32, 64'h020000C3);
        frame(8, 64'h06);
        frame(28, 64'h02FFFF1);
        chk({15'h0, busy}, 16'h0); // Cut data byte must not launch a write
        frame(8, 64'h04);
        frame(32, 64'h02FFFF11);
        expect_frame(40, 64'h03FFFF0000, 16'h3CC3);
        frame(8, 64'h06);
        m.start();
        m.shift(24, 64'h0202FE);
        for (int i = 0; i < 130; i++)
            m.shift(8, 64'(8'h10 + i));
        m.stop();
        wait_idle();
        expect_frame(40, 64'h0302FE0000, 16'h9091);
        expect_frame(40, 64'h0302800000, 16'h1213);
        write_op(16, 64'h0114);
        write_op(32, 64'h02C0005A);
        write_op(32, 64'h02BFFF66);
        expect_frame(40, 64'h03BFFF0000, 16'h66A5);
        write_op(16, 64'h0108);
        write_op(32, 64'h02BFFF55);
        expect_frame(40, 64'h03BFFF0000, 16'h66A5);
        write_op(16, 64'h010C);
        write_op(32, 64'h02000000);
        expect_frame(40, 64'h03FFFF0000, 16'h3CC3);
    endtask
    initial begin
        repeat (5) @(posedge clk_sys);
        reset <= 1'b0;
        repeat (4) @(posedge clk_sys);
        t_latch();
        t_swr();
        t_arr();
        conclude();
    end
    // The whole run needs about 25k cycles
    initial begin
        #(60000 * 100);
        n_mismatch++;
        $display("[FAIL] %0t watchdog expired", $time);
        conclude();
    end
endmodule
bind eepc_core eepc_assertions #(.WRITE_CYCLES(WRITE_CYCLES)) u_chk (.clk_sys(clk_sys),
    .reset(reset), .chip_sel_n(chip_sel_n), .ser_clk(ser_clk), .ser_out(ser_out),
    .ser_out_en(ser_out_en), .busy(busy));
`default_nettype wire
